// >>> hw/eplc_eye_ser.sv
// Purpose: Eye pattern serialiser with free-running shift clock
// Assumes: Clock enable freezes everything
// Notes: A sample is taken only at a falling shift-clock edge
`timescale 1ns/1ps
module eplc_eye_ser (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  eplc_smp_if.snk   smp,
  output logic      ser_out,
  output logic      sclk,
  output logic      strobe,
  output logic      busy
);
  import eplc_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_STROBE} eplc_ser_st_t;
  eplc_ser_st_t st_r, st_nxt;
  logic [8:0]   div_r, div_nxt;
  logic         sclk_r, sclk_nxt, ser_r, ser_nxt, stb_r, stb_nxt, fall;
  logic [4:0]   slot_r, slot_nxt;
  logic [29:0]  sh_r, sh_nxt, frame, chk_r;
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Data moves only when the shift clock falls, half a period before the receiver samples
  always_comb begin
    frame = {7'h00, smp.horiz, 7'h00, smp.vert};
    fall = (div_r == EYE_HALF_CYC - 9'h001) && sclk_r;
    div_nxt = fall || (div_r == EYE_HALF_CYC - 9'h001) ? 9'h000 : div_r + 9'h001;
    sclk_nxt = (div_r == EYE_HALF_CYC - 9'h001) ? !sclk_r : sclk_r;
    st_nxt = st_r;
    slot_nxt = slot_r;
    sh_nxt = sh_r;
    ser_nxt = ser_r;
    stb_nxt = stb_r;
    smp.ready = ce && fall && (st_r != ST_SHIFT);
    if (fall) begin
      case (st_r)
        ST_SHIFT: begin
          if (slot_r == LAST_SLOT) begin
            st_nxt = ST_STROBE;
            ser_nxt = 1'b0;
            stb_nxt = 1'b1;
          end else begin
            slot_nxt = slot_r + 5'h01;
            ser_nxt = sh_r[29];
            sh_nxt = {sh_r[28:0], 1'b0};
          end
        end
        default: begin
          stb_nxt = 1'b0;
          ser_nxt = 1'b0;
          st_nxt = ST_IDLE;
          if (smp.valid) begin
            st_nxt = ST_SHIFT;
            slot_nxt = 5'h00;
            ser_nxt = frame[29];
            sh_nxt = {frame[28:0], 1'b0};
          end
        end
      endcase
    end
  end
  // Register stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      div_r <= 9'h000;
      sclk_r <= 1'b1;
      slot_r <= 5'h00;
      sh_r <= 30'h0;
      ser_r <= 1'b0;
      stb_r <= 1'b0;
      chk_r <= 30'h0;
    end else if (ce) begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
      slot_r <= slot_nxt;
      sh_r <= sh_nxt;
      ser_r <= ser_nxt;
      stb_r <= stb_nxt;
      if (smp.ready && smp.valid) begin
        chk_r <= frame;
      end
    end
  end
  assign ser_out = ser_r;
  assign sclk = sclk_r;
  assign strobe = stb_r;
  assign busy = (st_r == ST_SHIFT);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_word_bit_order: assert property (@(posedge clk) disable iff (!arst_n)
    st_r == ST_SHIFT |-> ser_r == chk_r[5'd29 - slot_r])
    else $error("serial bit does not match captured frame");
  a_lead_zeros: assert property (@(posedge clk) disable iff (!arst_n)
    st_r == ST_SHIFT && (slot_r < 5'd7 || (slot_r >= 5'd15 && slot_r < 5'd22)) |-> !ser_r)
    else $error("leading word bit not zero");
  a_data_at_fall: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(ser_r) |-> $fell(sclk_r))
    else $error("serial data moved away from falling clock");
  a_strobe_alone: assert property (@(posedge clk) disable iff (!arst_n)
    stb_r |-> st_r == ST_STROBE && !ser_r && slot_r == LAST_SLOT)
    else $error("strobe outside its slot");
endmodule

// >>> hw/eplc_pkg.sv
// Purpose: Shared constants for the eye pattern and line control block
// Assumes: REF_CLK at 250 MHz
// Notes on behaviour
// - Each sample leaves as two 15-bit words, horizontal first, vertical right after.
// - Words go MSB first with seven leading zeros and eight coordinate bits.
// - Serial bits change on the falling shift clock so they are stable at its rising edge.
// - The shift clock is a free-running 288 kHz output.
// - A load strobe output tells the converters when both words are complete.
// - Ring pulse trains between 15 Hz and 68 Hz count as ringing, shown on the alert output and flag.
// - Software can reprogram the accepted ring period limits.
// - The alert output is low while ringing and high otherwise.
// - Relay one follows its control bit.
// - With caller-id enabled, a calling number message closes relay one.
// - Relay two follows its control bit.
// - Speaker monitor on/off and one of three attenuation levels come from control bits.
package eplc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 250_000_000;
  localparam int          EYE_CLK_HZ    = 288_000;
  localparam logic [8:0]  EYE_HALF_CYC  = 9'(CLK_HZ / (2 * EYE_CLK_HZ));
  localparam int          RING_MIN_HZ   = 15;
  localparam int          RING_MAX_HZ   = 68;
  localparam logic [24:0] RING_PER_MAX  = 25'(CLK_HZ / RING_MIN_HZ);
  localparam logic [24:0] RING_PER_MIN  = 25'((CLK_HZ + RING_MAX_HZ - 1) / RING_MAX_HZ);
  localparam logic [1:0]  RING_HITS     = 2'h2;
  // ----------------------------------------------------------------
  // Eye frame layout
  // ----------------------------------------------------------------
  localparam int          WORD_BITS     = 15;
  localparam int          COORD_BITS    = 8;
  localparam logic [4:0]  LAST_SLOT     = 5'h1d;
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_RING_MIN  = 8'h08;
  localparam logic [7:0]  REG_RING_MAX  = 8'h0c;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0040;
  localparam int          CB_RELAY_ONE  = 0;
  localparam int          CB_RELAY_TWO  = 1;
  localparam int          CB_CALLID     = 2;
  localparam int          CB_MON_ON     = 3;
  localparam int          CB_ATTEN_LO   = 4;
  localparam int          CB_EYE_EN     = 6;
endpackage

// >>> hw/eplc_ring_det.sv
// Purpose: Ring pulse frequency detector
// Assumes: Pin is asynchronous to clk
// Notes: Two in-range periods in a row declare ringing
`timescale 1ns/1ps
module eplc_ring_det (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        pin,
  input  wire logic [24:0] min_per,
  input  wire logic [24:0] max_per,
  output logic             ringing
);
  import eplc_pkg::*;
  logic [2:0]  sy_r;
  logic        lvl_r, lvl_nxt, edge_in, ring_r, ring_nxt;
  logic [24:0] per_r, per_nxt;
  logic [1:0]  hit_r, hit_nxt;
  // Period measured between rising edges; a change counts once stages two and three agree
  always_comb begin
    lvl_nxt = (sy_r[1] == sy_r[2]) ? sy_r[2] : lvl_r;
    edge_in = lvl_nxt && !lvl_r;
    per_nxt = (per_r > max_per) ? per_r : per_r + 25'h1;
    hit_nxt = hit_r;
    if (edge_in) begin
      per_nxt = 25'h0;
      if (per_r >= min_per && per_r <= max_per) begin
        hit_nxt = (hit_r == RING_HITS) ? RING_HITS : hit_r + 2'h1;
      end else begin
        hit_nxt = 2'h0;
      end
    end else if (per_r > max_per) begin
      hit_nxt = 2'h0;
    end
    ring_nxt = (hit_nxt == RING_HITS);
  end
  // Register stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sy_r <= 3'h0;
      lvl_r <= 1'b0;
      per_r <= 25'h1ffffff;
      hit_r <= 2'h0;
      ring_r <= 1'b0;
    end else if (ce) begin
      sy_r <= {sy_r[1:0], pin};
      lvl_r <= lvl_nxt;
      per_r <= per_nxt;
      hit_r <= hit_nxt;
      ring_r <= ring_nxt;
    end
  end
  assign ringing = ring_r;
  a_ring_timeout: assert property (@(posedge clk) disable iff (!arst_n)
    ce && per_r > max_per && !edge_in |=> !ring_r)
    else $error("ringing held past longest period");
endmodule

// >>> hw/eplc_smp_if.sv
// Purpose: Coordinate sample stream between buffer and serialiser
// Assumes: Valid/ready handshake, transfer when both high
// Notes: One sample is one horizontal and one vertical coordinate
`timescale 1ns/1ps
interface eplc_smp_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] horiz;
  logic [W-1:0] vert;
  modport src (output valid, output horiz, output vert, input ready);
  modport snk (input valid, input horiz, input vert, output ready);
endinterface

// >>> hw/eplc_top.sv
// Purpose: Eye pattern output and line control top level
// Assumes: Register port master per plain strobe protocol, same clock
// Notes: Relay pins are open drain, enable low while driving
`timescale 1ns/1ps
module eplc_top #(
  parameter logic [24:0] RING_MIN_CYC = eplc_pkg::RING_PER_MIN,
  parameter logic [24:0] RING_MAX_CYC = eplc_pkg::RING_PER_MAX
) (
  input  wire logic                       REF_CLK,
  input  wire logic                       ARST_N,
  input  wire logic                       CE,
  input  wire logic [7:0]                 REG_ADDR,
  input  wire logic [31:0]                REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic [31:0]                     REG_RDATA,
  input  wire logic                       SMP_VALID,
  output logic                            SMP_READY,
  input  wire logic [eplc_pkg::COORD_BITS-1:0] SMP_HORIZ,
  input  wire logic [eplc_pkg::COORD_BITS-1:0] SMP_VERT,
  input  wire logic                       CND_DETECT,
  input  wire logic                       RING_PULSE_INPUT,
  output logic                            EYE_SERIAL_OUT,
  output logic                            EYE_SHIFT_CLOCK,
  output logic                            EYE_LOAD_STROBE,
  output logic                            LINE_ALERT_OUT,
  output logic                            RELAY_ONE_DRIVE_O,
  output logic                            RELAY_ONE_DRIVE_OE_N,
  output logic                            RELAY_TWO_DRIVE_O,
  output logic                            RELAY_TWO_DRIVE_OE_N,
  output logic                            MONITOR_ON,
  output logic [1:0]                      MONITOR_ATTEN
);
  import eplc_pkg::*;
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
  logic [24:0] min_r, min_nxt, max_r, max_nxt;
  logic        cnd_r, cnd_nxt, ringing, eye_busy;
  logic        r1_r, r1_nxt, r2_r, r2_nxt, alert_r, alert_nxt;
  logic        mon_r, mon_nxt;
  logic [1:0]  att_r, att_nxt;
  logic [COORD_BITS-1:0] bh_r [2];
  logic [COORD_BITS-1:0] bv_r [2];
  logic [COORD_BITS-1:0] bh_nxt [2];
  logic [COORD_BITS-1:0] bv_nxt [2];
  logic        wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic        push, pop;

  eplc_smp_if #(.W(COORD_BITS)) smp ();

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Writes land the same cycle; read data is held for exactly one cycle after the strobe
  always_comb begin
    ctrl_nxt = ctrl_r;
    min_nxt = min_r;
    max_nxt = max_r;
    rdata_nxt = 32'h0;
    if (REG_WR) begin
      case (REG_ADDR)
        REG_CTRL:     ctrl_nxt = REG_WDATA & 32'h0000_007f;
        REG_RING_MIN: min_nxt = REG_WDATA[24:0];
        REG_RING_MAX: max_nxt = REG_WDATA[24:0];
        default:      ctrl_nxt = ctrl_r;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        REG_CTRL:     rdata_nxt = ctrl_r;
        REG_STATUS:   rdata_nxt = {27'h0, cnt_r == 2'h2, eye_busy, r2_r, r1_r, ringing};
        REG_RING_MIN: rdata_nxt = {7'h0, min_r};
        REG_RING_MAX: rdata_nxt = {7'h0, max_r};
        default:      rdata_nxt = 32'h0;
      endcase
    end
  end

  // Register stage for the software-visible state
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_r <= CTRL_RST;
      min_r <= RING_MIN_CYC;
      max_r <= RING_MAX_CYC;
      rdata_r <= 32'h0;
    end else if (CE) begin
      ctrl_r <= ctrl_nxt;
      min_r <= min_nxt;
      max_r <= max_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign REG_RDATA = rdata_r;

  // ----------------------------------------------------------------
  // Two-entry sample buffer
  // ----------------------------------------------------------------
  // Two entries let a new sample wait while a full frame is still shifting out
  always_comb begin
    push = SMP_VALID && (cnt_r != 2'h2);
    pop = smp.valid && smp.ready;
    bh_nxt = bh_r;
    bv_nxt = bv_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      bh_nxt[wp_r] = SMP_HORIZ;
      bv_nxt[wp_r] = SMP_VERT;
      wp_nxt = !wp_r;
    end
    if (pop) begin
      rp_nxt = !rp_r;
    end
    cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
  end

  // Register stage for the buffer
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bh_r[0] <= '0;
      bh_r[1] <= '0;
      bv_r[0] <= '0;
      bv_r[1] <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (CE) begin
      bh_r <= bh_nxt;
      bv_r <= bv_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // A cleared eye enable holds samples back; the buffer then fills and stalls the source
  assign SMP_READY = CE && (cnt_r != 2'h2);
  assign smp.valid = (cnt_r != 2'h0) && ctrl_r[CB_EYE_EN];
  assign smp.horiz = bh_r[rp_r];
  assign smp.vert = bv_r[rp_r];

  // ----------------------------------------------------------------
  // Serialiser and ring detector
  // ----------------------------------------------------------------
  eplc_eye_ser u_ser (
    .clk     (REF_CLK),
    .arst_n  (ARST_N),
    .ce      (CE),
    .smp     (smp.snk),
    .ser_out (EYE_SERIAL_OUT),
    .sclk    (EYE_SHIFT_CLOCK),
    .strobe  (EYE_LOAD_STROBE),
    .busy    (eye_busy)
  );

  eplc_ring_det u_ring (
    .clk     (REF_CLK),
    .arst_n  (ARST_N),
    .ce      (CE),
    .pin     (RING_PULSE_INPUT),
    .min_per (min_r),
    .max_per (max_r),
    .ringing (ringing)
  );

  // ----------------------------------------------------------------
  // Line control outputs
  // ----------------------------------------------------------------
  // The caller-id latch clears only with its enable, and a cleared enable wins over a message in the same cycle
  always_comb begin
    cnd_nxt = ctrl_r[CB_CALLID] && (CND_DETECT || cnd_r);
    r1_nxt = ctrl_r[CB_RELAY_ONE] || cnd_nxt;
    r2_nxt = ctrl_r[CB_RELAY_TWO];
    alert_nxt = !ringing;
    mon_nxt = ctrl_r[CB_MON_ON];
    // Code 3 is not a level of its own and maps to the strongest one
    att_nxt = (ctrl_r[CB_ATTEN_LO +: 2] == 2'h3) ? 2'h2 : ctrl_r[CB_ATTEN_LO +: 2];
  end

  // Register stage for the pins
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnd_r <= 1'b0;
      r1_r <= 1'b0;
      r2_r <= 1'b0;
      alert_r <= 1'b1;
      mon_r <= 1'b0;
      att_r <= 2'h0;
    end else if (CE) begin
      cnd_r <= cnd_nxt;
      r1_r <= r1_nxt;
      r2_r <= r2_nxt;
      alert_r <= alert_nxt;
      mon_r <= mon_nxt;
      att_r <= att_nxt;
    end
  end
  // Relays pull low when active and float otherwise
  assign RELAY_ONE_DRIVE_O = 1'b0;
  assign RELAY_ONE_DRIVE_OE_N = !r1_r;
  assign RELAY_TWO_DRIVE_O = 1'b0;
  assign RELAY_TWO_DRIVE_OE_N = !r2_r;
  assign LINE_ALERT_OUT = alert_r;
  assign MONITOR_ON = mon_r;
  assign MONITOR_ATTEN = att_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_relay_one_follow: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    CE && ctrl_r[CB_RELAY_ONE] |=> !RELAY_ONE_DRIVE_OE_N)
    else $error("relay one not driven");
  a_relay_two_follow: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    CE |=> RELAY_TWO_DRIVE_OE_N == !$past(ctrl_r[CB_RELAY_TWO]))
    else $error("relay two does not follow control");
  a_callid_close: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    CE && ctrl_r[CB_CALLID] && CND_DETECT ##1 CE && ctrl_r[CB_CALLID] |=> !RELAY_ONE_DRIVE_OE_N)
    else $error("caller id did not close relay one");
  a_alert_level: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    CE |=> LINE_ALERT_OUT == !$past(ringing))
    else $error("alert output not inverse of ringing");
  a_atten_levels: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    MONITOR_ATTEN != 2'h3)
    else $error("attenuation outside three levels");
  a_strobe_load: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    $rose(EYE_LOAD_STROBE) |-> !eye_busy && $past(eye_busy))
    else $error("strobe not right after a frame");
  // An accepted sample with no pop must grow the count, so a lost push shows up here
  a_buffer_bound: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    CE && SMP_VALID && SMP_READY && !(smp.valid && smp.ready) |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("buffer count missed an accepted sample");
endmodule

// >>> verif/eplc_eye_rx.sv
// Purpose: Model of the serial-to-parallel and D/A converters behind the eye pins
// Assumes: Bits are captured on the rising shift clock and loaded on the strobe
// Notes: Counts captured bits per frame, so a short or long frame shows up
`timescale 1ns/1ps
module eplc_eye_rx (
  input  wire logic        sclk,
  input  wire logic        sdat,
  input  wire logic        strobe,
  output logic      [14:0] horiz_w,
  output logic      [14:0] vert_w,
  output int               bits,
  output int               frames
);
  logic [29:0] sh;
  int          cnt;

  initial begin
    sh      = '0;
    cnt     = 0;
    bits    = 0;
    frames  = 0;
    horiz_w = '0;
    vert_w  = '0;
  end

  // Shift in on the rising shift clock; a strobe seen there restarts the count
  always @(posedge sclk) begin
    sh  <= {sh[28:0], sdat};
    cnt <= strobe ? 0 : cnt + 1;
  end

  // Load both converters on the strobe, horizontal word first in the stream
  always @(posedge strobe) begin
    horiz_w <= sh[29:15];
    vert_w  <= sh[14:0];
    bits    <= cnt;
    frames  <= frames + 1;
  end
endmodule

// >>> verif/tb_eplc_top.sv
// Purpose: Self-checking bench for the eye pattern and line control block
// Assumes: Register port with one-cycle strobes, read data in the next cycle
// Notes: Small ring limits keep the ring scenarios short
`timescale 1ns/1ps
module tb_eplc_top;
  import eplc_pkg::*;
  logic        clk, arst_n, wr, rd, valid, cnd, ring_in, ring_on;
  logic [7:0]  addr, hz, vt;
  logic [31:0] wdata, rdata, d;
  logic        ready, sdat, sclk, strb, alert, r1_o, r1_oe_n, r2_o, r2_oe_n, mon_on, sclk_q, strb_q;
  logic [1:0]  atten;
  logic [14:0] rx_h, rx_v;
  int          rx_bits, rx_frames, failures, cmp_count, cyc, sclk_cnt, sclk_per, strb_cnt, strb_w;

  eplc_top #(.RING_MIN_CYC(25'd20), .RING_MAX_CYC(25'd100)) uut (
    .REF_CLK(clk), .ARST_N(arst_n), .CE(1'b1), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SMP_VALID(valid), .SMP_READY(ready),
    .SMP_HORIZ(hz), .SMP_VERT(vt), .CND_DETECT(cnd), .RING_PULSE_INPUT(ring_in),
    .EYE_SERIAL_OUT(sdat), .EYE_SHIFT_CLOCK(sclk), .EYE_LOAD_STROBE(strb),
    .LINE_ALERT_OUT(alert), .RELAY_ONE_DRIVE_O(r1_o), .RELAY_ONE_DRIVE_OE_N(r1_oe_n),
    .RELAY_TWO_DRIVE_O(r2_o), .RELAY_TWO_DRIVE_OE_N(r2_oe_n), .MONITOR_ON(mon_on),
    .MONITOR_ATTEN(atten));

  eplc_eye_rx rx (.sclk(sclk), .sdat(sdat), .strobe(strb), .horiz_w(rx_h), .vert_w(rx_v),
    .bits(rx_bits), .frames(rx_frames));

  // ----------------------------------------------------------------
  // Clocks, ring pulses and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Ring pulses at 160 ns period, odd phase; still while no ring is wanted
  initial begin
    ring_in = 1'b0;
    #3;
    forever begin
      #80;
      ring_in = ring_on ? ~ring_in : 1'b0;
    end
  end

  // Shift clock period and strobe width in REF_CLK cycles; edges found on sampled values to avoid races
  always @(posedge clk) begin
    cyc      <= cyc + 1;
    sclk_q   <= sclk;
    strb_q   <= strb;
    sclk_cnt <= (sclk && !sclk_q) ? 1 : sclk_cnt + 1;
    strb_cnt <= strb ? strb_cnt + 1 : 0;
    if (sclk && !sclk_q) begin
      sclk_per <= sclk_cnt;
    end
    if (!strb && strb_q) begin
      strb_w <= strb_cnt;
    end
    if (cyc == 90000) begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Offer one sample and hold it until the buffer takes it
  task automatic push(input logic [7:0] h, input logic [7:0] v);
    valid <= 1'b1;
    hz    <= h;
    vt    <= v;
    #1;
    while (ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rreg(REG_CTRL, d);     chk(d, CTRL_RST);
    rreg(REG_RING_MIN, d); chk(d, 32'd20);
    rreg(REG_RING_MAX, d); chk(d, 32'd100);
    rreg(8'h10, d);        chk(d, 32'h0);
    chk({alert, r1_oe_n, r2_oe_n}, 3'h7);
  endtask

  task automatic t_relays;
    wreg(REG_CTRL, 32'h43);
    repeat (3) @(posedge clk);
    chk({r1_o, r1_oe_n, r2_o, r2_oe_n}, 4'h0);
    wreg(REG_STATUS, 32'h0);
    rreg(REG_STATUS, d);   chk(d & 32'h6, 32'h6);
    wreg(REG_CTRL, 32'h41);
    repeat (3) @(posedge clk);
    chk({r1_oe_n, r2_oe_n}, 2'h1);
    wreg(REG_CTRL, 32'h40);
    repeat (3) @(posedge clk);
    chk(r1_oe_n, 1'b1);
  endtask

  task automatic t_callid;
    wreg(REG_CTRL, 32'h44);
    @(posedge clk) cnd <= 1'b1;
    @(posedge clk) cnd <= 1'b0;
    repeat (2) @(posedge clk);
    chk(r1_oe_n, 1'b0);
    wreg(REG_CTRL, 32'h40);
    repeat (3) @(posedge clk);
    chk(r1_oe_n, 1'b1);
  endtask

  task automatic t_monitor;
    for (int a = 0; a < 4; a++) begin
      wreg(REG_CTRL, 32'h48 | (a << 4));
      repeat (3) @(posedge clk);
      chk({mon_on, atten}, {1'b1, (a == 3) ? 2'h2 : 2'(a)});
    end
    wreg(REG_CTRL, 32'h40);
    repeat (3) @(posedge clk);
    chk(mon_on, 1'b0);
  endtask

  task automatic t_ring;
    ring_on = 1'b1;
    repeat (300) @(posedge clk);
    chk(alert, 1'b0);
    rreg(REG_STATUS, d);   chk(d[0], 1'b1);
    ring_on = 1'b0;
    repeat (300) @(posedge clk);
    chk(alert, 1'b1);
    wreg(REG_RING_MIN, 32'd60);
    ring_on = 1'b1;
    repeat (300) @(posedge clk);
    chk(alert, 1'b1);
    ring_on = 1'b0;
    wreg(REG_RING_MIN, 32'd20);
    // A 40-cycle period above a lowered upper limit must not count as ringing
    wreg(REG_RING_MAX, 32'd30);
    rreg(REG_RING_MAX, d); chk(d, 32'd30);
    ring_on = 1'b1;
    repeat (300) @(posedge clk);
    chk(alert, 1'b1);
    ring_on = 1'b0;
    wreg(REG_RING_MAX, 32'd100);
  endtask

  task automatic t_eye;
    wreg(REG_CTRL, 32'h00);
    @(posedge clk);
    push(8'ha5, 8'h3c);
    push(8'h81, 8'h7e);
    valid <= 1'b0;
    #1;
    chk(ready, 1'b0);
    rreg(REG_STATUS, d);   chk(d[4], 1'b1);
    wreg(REG_CTRL, 32'h40);
    for (int i = 0; i < 40000 && rx_frames < 1; i++) @(posedge clk);
    chk({rx_h, rx_v}, {15'h00a5, 15'h003c});
    // Strobe slot is not shifting; wait into the second frame, buffer now drained
    repeat (1000) @(posedge clk);
    rreg(REG_STATUS, d);   chk(d[4:3], 2'h1);
    for (int i = 0; i < 40000 && rx_frames < 2; i++) @(posedge clk);
    chk({rx_h, rx_v}, {15'h0081, 15'h007e});
    chk(rx_bits, 30);
    repeat (1000) @(posedge clk);
    chk(strb_w, 2 * EYE_HALF_CYC);
    chk(sclk_per, 2 * EYE_HALF_CYC);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, wr, rd, valid, cnd, ring_on, sclk_q, strb_q} = '0;
    {addr, hz, vt, wdata} = '0;
    {failures, cmp_count, cyc, sclk_cnt, sclk_per, strb_cnt, strb_w} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_relays();
    t_callid();
    t_monitor();
    t_ring();
    t_eye();
    print_verdict();
  end
endmodule
